//--- verilog/adm_decoder.sv
// Operand address-mode decoder of the 8-bit core.
// Assumes a memory port answering each held read with mem_valid, and an
// opcode table that returns op_mode for opcode in the decode cycle.
// Function
// - Short direct: one address byte, page zero
// - Long direct: two bytes, full 64K address
// - Indexed: unsigned sum of index and offset
// - No-offset indexed: no byte, address is index
// - Short indexed: byte offset plus index, to 1FE
// - Long indexed: word offset plus index
// - Indirect: pointer read at page-zero address byte
// - Short indirect: byte pointer, page-zero operand
// - Long indirect: word pointer, full space
// - Indirect indexed: pointer plus X or Y
// - Short indirect indexed: byte pointer, to 1FE
// - Memory-to-memory ops allow short forms only
// - Relative: pc plus signed 8-bit offset
// - Relative direct: offset byte follows opcode
// - Relative indirect: offset read from memory
// - Prefix, opcode, then zero to two bytes
// - Prefix 90 swaps X for Y
// - Prefix 92 makes direct forms indirect
// - Prefix 92 makes short and long X-indexed indirect indexed; no-offset indexed is illegal
// - Prefix 91 uses Y in indirect indexed
`timescale 1ns/10ps
`default_nettype none
module adm_decoder (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic [15:0]        pc_in,
  input  wire logic [7:0]         x_in,
  input  wire logic [7:0]         y_in,
  input  wire adm_pkg::adm_mode_t op_mode,
  input  wire logic               short_only,
  output logic [7:0]              opcode,
  output logic                    mem_rd,
  output logic [15:0]             mem_addr,
  input  wire logic [7:0]         mem_rdata,
  input  wire logic               mem_valid,
  output logic                    busy,
  output logic                    done,
  output logic [15:0]             ea,
  output logic [15:0]             rel_target,
  output logic [15:0]             next_pc,
  output logic                    is_rel,
  output logic                    is_ind,
  output logic                    use_y,
  output logic                    illegal
);
  import adm_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_OPC, S_DEC, S_ADR, S_PTR, S_ROFF, S_DONE
  } adm_state_t;

  adm_state_t  state_ff, nxt_state;
  adm_pfx_t    pfx_ff;
  adm_mode_t   mode_ff;
  adm_eff_t    eff_ff, eff_now;
  logic        sonly_ff;
  logic [7:0]  opcode_ff, idx_ff, off_ff, ptr_a_ff;
  logic [15:0] pc_ff, opnd_pc_ff, mem_addr_ff;
  logic        mem_rd_ff;
  logic [1:0]  adr_left_ff;
  logic        ptr_more_ff;
  logic        rd_ok, issue, is_pfx;
  logic [15:0] issue_addr;
  logic        done_ff, ill_o_ff, y_o_ff, rel_o_ff, ind_o_ff;
  logic [15:0] ea_o_ff, tgt_o_ff, npc_o_ff;
  adm_pfx_t    pfx_code;

  adm_ea_if ea_if ();

  // ==========================================================
  // Submodules
  adm_byte_pair u_pair (
    .clk (clk),
    .rst (rst),
    .pif (ea_if.pair)
  );

  adm_ea_calc u_calc (
    .cif (ea_if.calc)
  );

  // ==========================================================
  // Prefix recognition
  always_comb begin
    is_pfx   = 1'b1;
    pfx_code = P_NONE;
    unique case (mem_rdata)
      PFX_Y_SWAP_CODE:   pfx_code = P_Y;
      PFX_IND_Y_CODE:    pfx_code = P_IY;
      PFX_INDIRECT_CODE: pfx_code = P_IND;
      default:           is_pfx = 1'b0;
    endcase
  end

  assign rd_ok   = mem_rd_ff && mem_valid;
  assign eff_now = adm_decode(op_mode, pfx_ff, short_only);

  // ==========================================================
  // Sequencer: next state and read issue
  always_comb begin
    nxt_state  = state_ff;
    issue      = 1'b0;
    issue_addr = mem_addr_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (start) begin
          issue      = 1'b1;
          issue_addr = pc_in;
          nxt_state  = S_OPC;
        end
      end
      S_OPC: begin
        if (rd_ok) begin
          if (is_pfx && pfx_ff == P_NONE) begin
            issue      = 1'b1;
            issue_addr = pc_ff + 16'h0001;
          end else begin
            nxt_state = S_DEC;
          end
        end
      end
      S_DEC: begin
        if (eff_now.ill || eff_now.n_adr == 2'h0) begin
          nxt_state = S_DONE;
        end else begin
          issue      = 1'b1;
          issue_addr = pc_ff;
          nxt_state  = S_ADR;
        end
      end
      S_ADR: begin
        if (rd_ok) begin
          if (adr_left_ff != ONE_BYTE) begin
            issue      = 1'b1;
            issue_addr = pc_ff + 16'h0001;
          end else if (eff_ff.ind) begin
            issue      = 1'b1;
            issue_addr = {PAGE_ZERO_HI, mem_rdata};
            nxt_state  = S_PTR;
          end else if (eff_ff.bitrel) begin
            issue      = 1'b1;
            issue_addr = pc_ff + 16'h0001;
            nxt_state  = S_ROFF;
          end else begin
            nxt_state = S_DONE;
          end
        end
      end
      S_PTR: begin
        if (rd_ok) begin
          if (ptr_more_ff) begin
            issue      = 1'b1;
            issue_addr = {PAGE_ZERO_HI, ptr_a_ff + 8'h01};
          end else if (eff_ff.bitrel) begin
            issue      = 1'b1;
            issue_addr = pc_ff;
            nxt_state  = S_ROFF;
          end else begin
            nxt_state = S_DONE;
          end
        end
      end
      S_ROFF: begin
        if (rd_ok) begin
          nxt_state = S_DONE;
        end
      end
      S_DONE: nxt_state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Memory read port, request held until answered
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd_ff   <= 1'b0;
      mem_addr_ff <= ADDR_RST;
    end else if (issue) begin
      mem_rd_ff   <= 1'b1;
      mem_addr_ff <= issue_addr;
    end else if (rd_ok) begin
      mem_rd_ff <= 1'b0;
    end
  end

  // Stream pointer, advanced on each instruction byte taken
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff <= ADDR_RST;
    end else if (state_ff == S_IDLE && start) begin
      pc_ff <= pc_in;
    end else if (rd_ok && state_ff inside {S_OPC, S_ADR, S_ROFF}) begin
      pc_ff <= pc_ff + 16'h0001;
    end
  end

  // ==========================================================
  // Prefix, opcode and fetch plan capture
  always_ff @(posedge clk) begin
    if (rst) begin
      pfx_ff     <= P_NONE;
      opcode_ff  <= BYTE_RST;
      mode_ff    <= M_INH;
      eff_ff     <= '0;
      sonly_ff   <= 1'b0;
      idx_ff     <= BYTE_RST;
      opnd_pc_ff <= ADDR_RST;
    end else if (state_ff == S_IDLE && start) begin
      pfx_ff <= P_NONE;
    end else if (state_ff == S_OPC && rd_ok) begin
      if (is_pfx && pfx_ff == P_NONE) begin
        pfx_ff <= pfx_code;
      end else begin
        opcode_ff <= mem_rdata;
      end
    end else if (state_ff == S_DEC) begin
      mode_ff    <= op_mode;
      eff_ff     <= eff_now;
      sonly_ff   <= short_only;
      idx_ff     <= eff_now.use_y ? y_in : x_in;
      opnd_pc_ff <= pc_ff;
    end
  end

  // Byte counters and pointer address
  always_ff @(posedge clk) begin
    if (rst) begin
      adr_left_ff <= 2'h0;
      ptr_more_ff <= 1'b0;
      ptr_a_ff    <= BYTE_RST;
    end else if (state_ff == S_DEC) begin
      adr_left_ff <= eff_now.n_adr;
    end else if (state_ff == S_ADR && rd_ok) begin
      adr_left_ff <= adr_left_ff - 2'h1;
      ptr_more_ff <= eff_ff.pword;
      ptr_a_ff    <= mem_rdata;
    end else if (state_ff == S_PTR && rd_ok) begin
      ptr_more_ff <= 1'b0;
    end
  end

  // Offset byte that follows a bit address
  always_ff @(posedge clk) begin
    if (rst) begin
      off_ff <= BYTE_RST;
    end else if (state_ff == S_ROFF && rd_ok) begin
      off_ff <= mem_rdata;
    end
  end

  // ==========================================================
  // Word assembly and adder hookup
  always_comb begin
    ea_if.clr    = (state_ff == S_DEC) || (state_ff == S_ADR && rd_ok && eff_ff.ind
                   && adr_left_ff == ONE_BYTE);
    ea_if.shift  = rd_ok && state_ff inside {S_ADR, S_PTR};
    ea_if.din    = mem_rdata;
    ea_if.idx    = idx_ff;
    ea_if.idx_en = eff_ff.idx_en;
    ea_if.pc     = pc_ff;
    ea_if.off    = eff_ff.bitrel ? off_ff : ea_if.word[7:0];
  end

  // ==========================================================
  // Result registers, loaded as the sequence ends
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff  <= 1'b0;
      ea_o_ff  <= ADDR_RST;
      tgt_o_ff <= ADDR_RST;
      npc_o_ff <= ADDR_RST;
      ill_o_ff <= 1'b0;
      y_o_ff   <= 1'b0;
      rel_o_ff <= 1'b0;
      ind_o_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == S_DONE);
      if (state_ff == S_DONE) begin
        ea_o_ff  <= ea_if.ea;
        tgt_o_ff <= ea_if.tgt;
        npc_o_ff <= pc_ff;
        ill_o_ff <= eff_ff.ill;
        y_o_ff   <= eff_ff.use_y;
        rel_o_ff <= eff_ff.rel;
        ind_o_ff <= eff_ff.ind;
      end
    end
  end

  assign opcode     = opcode_ff;
  assign mem_rd     = mem_rd_ff;
  assign mem_addr   = mem_addr_ff;
  assign busy       = (state_ff != S_IDLE);
  assign done       = done_ff;
  assign ea         = ea_o_ff;
  assign rel_target = tgt_o_ff;
  assign next_pc    = npc_o_ff;
  assign is_rel     = rel_o_ff;
  assign is_ind     = ind_o_ff;
  assign use_y      = y_o_ff;
  assign illegal    = ill_o_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SHORT_DIRECT: assert property (
    done && mode_ff == M_DIR_S && pfx_ff == P_NONE |-> ea[15:8] == 8'h00)
    else $error("short direct address left page zero");
  AST_LENGTH: assert property (
    done && !illegal |-> next_pc - opnd_pc_ff ==
      16'(eff_ff.n_adr) + 16'(eff_ff.bitrel))
    else $error("instruction length does not match mode");
  AST_NO_OFFSET: assert property (
    done && mode_ff == M_IX0 && !illegal |-> ea == {8'h00, idx_ff}
      && next_pc == opnd_pc_ff)
    else $error("no-offset indexed address wrong");
  AST_SHORT_IDX: assert property (
    done && mode_ff == M_IXS && !is_ind |-> ea <= 16'h01fe)
    else $error("short indexed address beyond 1FE");
  AST_SHORT_ONLY: assert property (
    done && sonly_ff && mode_ff inside {M_DIR_L, M_IXL} |-> illegal)
    else $error("long form accepted for short-only op");
  AST_PFX_Y: assert property (
    done && pfx_ff == P_Y && !illegal |-> use_y && !is_ind)
    else $error("prefix 90 did not select Y");
  AST_PFX_IY: assert property (
    done && pfx_ff == P_IY && !illegal |-> use_y && is_ind)
    else $error("prefix 91 did not give Y indirect indexed");
  AST_PFX_IND: assert property (
    done && pfx_ff == P_IND && !illegal |-> is_ind && !use_y)
    else $error("prefix 92 did not give indirect form");
  AST_PTR_PAGE0: assert property (
    state_ff == S_PTR && mem_rd |-> mem_addr[15:8] == 8'h00)
    else $error("pointer read outside page zero");
  AST_REL_TGT: assert property (
    done && is_rel && !illegal |-> rel_target ==
      next_pc + {{8{$past(ea_if.off[7])}}, $past(ea_if.off)})
    else $error("relative target wrong");
  AST_RD_HOLD: assert property (
    mem_rd && !mem_valid |=> mem_rd && $stable(mem_addr))
    else $error("read request dropped before answer");
  AST_DONE_PULSE: assert property (
    state_ff == S_DONE |=> done ##1 !done)
    else $error("done is not a single pulse");
  COV_PFX_IND_WORD: cover property (done && pfx_ff == P_IND && mode_ff == M_IXL);
  COV_BIT_REL_IND: cover property (done && mode_ff == M_BIT_REL && is_ind);
  COV_PFX_IY: cover property (done && pfx_ff == P_IY && !illegal);
  COV_ILLEGAL: cover property (done && illegal);

endmodule // adm_decoder
`default_nettype wire

//--- common/adm_pkg.sv
// Package for the operand address-mode decoder.
// Holds prefix codes, mode and prefix types, reset values and the
// mode-to-sequence decode used by the decoder; the tests predict on their own.
`default_nettype none
package adm_pkg;

  // ==========================================================
  // Constants
  localparam logic [7:0]  PFX_Y_SWAP_CODE   = 8'h90;  // prefix_y_swap
  localparam logic [7:0]  PFX_IND_Y_CODE    = 8'h91;  // prefix_indirect_y
  localparam logic [7:0]  PFX_INDIRECT_CODE = 8'h92;  // prefix_indirect
  localparam logic [7:0]  PAGE_ZERO_HI      = 8'h00;
  localparam logic [15:0] ADDR_RST          = 16'h0000;
  localparam logic [7:0]  BYTE_RST          = 8'h00;
  localparam logic [1:0]  ONE_BYTE          = 2'h1;
  localparam logic [1:0]  TWO_BYTES         = 2'h2;

  // ==========================================================
  // Types
  // Base addressing mode of the opcode, as given by the opcode table
  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IX0, M_IXS, M_IXL,
    M_REL, M_BIT, M_BIT_REL
  } adm_mode_t;

  typedef enum logic [1:0] {P_NONE, P_Y, P_IY, P_IND} adm_pfx_t;

  // Fetch plan of one instruction after prefix and opcode
  typedef struct packed {
    logic [1:0] n_adr;   // stream bytes after opcode for address
    logic       ind;     // pointer read from page zero
    logic       pword;   // pointer is a word
    logic       idx_en;  // index register added
    logic       use_y;   // Y replaces X
    logic       rel;     // relative target produced
    logic       bitrel;  // offset byte follows the address byte
    logic       ill;     // combination not allowed
  } adm_eff_t;

  // ==========================================================
  // Functions
  // Mode and prefix to fetch plan
  function automatic adm_eff_t adm_decode(adm_mode_t m, adm_pfx_t p, logic sonly);
    adm_eff_t e;
    e = '0;
    unique case (m)
      M_INH, M_IMM: begin
        e.use_y = (p == P_Y);
        e.ill   = (p == P_IY) || (p == P_IND);
      end
      M_DIR_S: begin
        e.n_adr = ONE_BYTE;
        e.use_y = (p == P_Y);
        e.ind   = (p == P_IND);
        e.ill   = (p == P_IY);
      end
      M_DIR_L: begin
        e.n_adr = (p == P_IND) ? ONE_BYTE : TWO_BYTES;
        e.ind   = (p == P_IND);
        e.pword = (p == P_IND);
        e.use_y = (p == P_Y);
        e.ill   = (p == P_IY) || sonly;
      end
      M_IX0: begin
        e.idx_en = 1'b1;
        e.use_y  = (p == P_Y);
        e.ill    = (p == P_IY) || (p == P_IND);
      end
      M_IXS, M_IXL: begin
        e.idx_en = 1'b1;
        e.ind    = (p == P_IND) || (p == P_IY);
        e.n_adr  = (m == M_IXL && !e.ind) ? TWO_BYTES : ONE_BYTE;
        e.pword  = e.ind && (m == M_IXL);
        e.use_y  = (p == P_Y) || (p == P_IY);
        e.ill    = sonly && (m == M_IXL);
      end
      M_REL: begin
        e.n_adr = ONE_BYTE;
        e.rel   = 1'b1;
        e.ind   = (p == P_IND);
        e.ill   = (p == P_Y) || (p == P_IY);
      end
      M_BIT, M_BIT_REL: begin
        e.n_adr  = ONE_BYTE;
        e.ind    = (p == P_IND);
        e.bitrel = (m == M_BIT_REL);
        e.rel    = (m == M_BIT_REL);
        e.ill    = (p == P_Y) || (p == P_IY);
      end
      default: e.ill = 1'b1;
    endcase
    return e;
  endfunction

  // Program counter plus signed 8-bit offset
  function automatic logic [15:0] adm_rel_add(logic [15:0] pc, logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

endpackage
`default_nettype wire

//--- common/adm_ea_if.sv
// Interface between decoder control, byte assembler and address adder.
// Assumes decoder and byte assembler share one clock; the address adder is combinational.
`timescale 1ns/10ps
`default_nettype none
interface adm_ea_if;
  logic        clr;     // clear assembled word
  logic        shift;   // shift in one byte
  logic [7:0]  din;     // byte from memory
  logic [15:0] word;    // assembled word, first byte high
  logic [7:0]  idx;     // index register value
  logic        idx_en;  // add index
  logic [15:0] pc;      // pc after the instruction
  logic [7:0]  off;     // signed relative offset
  logic [15:0] ea;      // effective address
  logic [15:0] tgt;     // relative target

  modport ctl  (output clr, shift, din, idx, idx_en, pc, off,
                input word, ea, tgt);
  modport pair (input clr, shift, din, output word);
  modport calc (input word, idx, idx_en, pc, off, output ea, tgt);
endinterface // adm_ea_if
`default_nettype wire

//--- verilog/adm_byte_pair.sv
// Assembles address, offset and pointer bytes into a 16-bit word.
// Assumes bytes arrive in memory order, lower address first.
`timescale 1ns/10ps
`default_nettype none
module adm_byte_pair (
  input  wire logic clk,
  input  wire logic rst,
  adm_ea_if.pair    pif
);
  import adm_pkg::*;

  logic [15:0] word_ff;

  // ==========================================================
  // Shift register, first byte ends up high
  always_ff @(posedge clk) begin
    if (rst || pif.clr) begin
      word_ff <= ADDR_RST;
    end else if (pif.shift) begin
      word_ff <= {word_ff[7:0], pif.din};
    end
  end

  assign pif.word = word_ff;
endmodule // adm_byte_pair
`default_nettype wire

//--- verilog/adm_ea_calc.sv
// Effective address and relative target adder.
// Assumes the word input is stable in the cycle it is used.
`timescale 1ns/10ps
`default_nettype none
module adm_ea_calc (
  adm_ea_if.calc cif
);
  import adm_pkg::*;

  // ==========================================================
  // Unsigned index add and signed pc add
  always_comb begin
    cif.ea  = cif.word + (cif.idx_en ? {PAGE_ZERO_HI, cif.idx} : ADDR_RST);
    cif.tgt = adm_rel_add(cif.pc, cif.off);
  end
endmodule // adm_ea_calc
`default_nettype wire

//--- sim/adm_mem_model.sv
// Behavioural program and data memory for the address-mode decoder.
// Assumes the bench loads bytes into mem and sets wait_n between reads.
`timescale 1ns/10ps
`default_nettype none
module adm_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  input  wire logic [1:0]  wait_n,
  output logic [7:0]       mem_rdata,
  output logic             mem_valid
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt_ff;
  logic [7:0] last_ff;
  logic       junk_ff;

  // ==========================================================
  // Wait counter, restarts after each answer
  always_ff @(posedge clk) begin
    if (rst || !mem_rd || mem_valid) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end

  // Last byte given, idle toggle on the answer line
  always_ff @(posedge clk) begin
    junk_ff <= rst ? 1'b0 : ~junk_ff;
    if (rst) last_ff <= 8'h5a;
    else if (mem_rd && mem_valid) last_ff <= mem_rdata;
  end

  // Byte when answering, inverse of last byte otherwise
  assign mem_valid = mem_rd ? (cnt_ff >= wait_n) : junk_ff;
  assign mem_rdata = (mem_rd && mem_valid) ? mem[mem_addr] : ~last_ff;
endmodule // adm_mem_model
`default_nettype wire

//--- sim/cpu_address_mode_decoder_test.sv
// Self-checking bench of the operand address-mode decoder.
// Assumes adm_decoder facing the behavioural memory adm_mem_model.
`timescale 1ns/10ps
`default_nettype none
module cpu_address_mode_decoder_test;
  import adm_pkg::*;
  logic        clk, rst, start, short_only, mem_rd, mem_valid, busy, done;
  logic        is_rel, is_ind, use_y, illegal;
  logic [15:0] pc_in, mem_addr, ea, rel_target, next_pc;
  logic [7:0]  x_in, y_in, opcode, mem_rdata;
  adm_mode_t   op_mode;
  logic [1:0]  wait_n;
  int          n_errors, checks_done, seed_v;
  localparam logic [7:0] PFX_TAB [4] = '{8'h00, PFX_Y_SWAP_CODE, PFX_IND_Y_CODE,
                                         PFX_INDIRECT_CODE};

  adm_decoder u_dut (.clk, .rst, .start, .pc_in, .x_in, .y_in, .op_mode, .short_only,
    .opcode, .mem_rd, .mem_addr, .mem_rdata, .mem_valid, .busy, .done, .ea,
    .rel_target, .next_pc, .is_rel, .is_ind, .use_y, .illegal);
  adm_mem_model u_mem (.clk, .rst, .mem_rd, .mem_addr, .wait_n, .mem_rdata, .mem_valid);

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // ==========================================================
  // Compare, verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Expected relative target: base plus sign-extended offset
  function automatic logic [15:0] exp_tgt(input logic [15:0] base, input logic [7:0] o);
    return base + {{8{o[7]}}, o};
  endfunction

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // One instruction: load memory, predict, start, wait, compare
  task automatic run_one(input int m, input int p, input bit so, input int rnd);
    logic [15:0] pc, b, e_ea, e_npc, e_tgt, pw;
    logic [7:0]  op, s0, s1, pb, ix, off;
    logic        e_ill, e_ind, e_y, chk_ea, chk_np, chk_rel;
    int          k;
    pc = 16'h1000 + 16'($urandom_range(0, 16'hdfff));
    op = 8'($urandom_range(0, 8'h8f));
    b = pc + 16'(p != 0) + 16'h1;
    s0 = (rnd == 0) ? 8'hff : 8'($urandom);
    s1 = (rnd == 0) ? 8'hff : 8'($urandom);
    if (p != 0) u_mem.mem[pc] = PFX_TAB[p];
    u_mem.mem[b - 16'h1] = op;
    u_mem.mem[b] = s0;
    u_mem.mem[b + 16'h1] = s1;
    u_mem.mem[b + 16'h2] = 8'($urandom);
    u_mem.mem[{8'h00, s0}] = (rnd == 0) ? 8'hff : 8'($urandom);
    u_mem.mem[{8'h00, s0 + 8'h1}] = 8'($urandom); // Page-zero wrap at ff
    pb = u_mem.mem[{8'h00, s0}];
    pw = {pb, u_mem.mem[{8'h00, s0 + 8'h1}]}; // High byte first
    x_in = (rnd == 0) ? 8'hff : 8'($urandom);
    y_in = (rnd == 0) ? 8'hff : 8'($urandom);
    ix = (p == 1 || p == 2) ? y_in : x_in;
    // Expected outcome of this mode and prefix
    e_ill = 1'b0;
    e_ind = (p == 3);
    e_y = (p == 1);
    e_npc = b + 16'h1;
    e_ea = {8'h00, e_ind ? pb : s0};
    e_tgt = 16'h0000;
    chk_ea = 1'b1;
    chk_np = 1'b1;
    chk_rel = 1'b0;
    case (m)
      0, 1: begin
        e_ill = (p > 1);
        chk_ea = 1'b0;
        chk_np = (m == 0);
        e_npc = b;
      end
      2: e_ill = (p == 2);
      3: begin
        e_ill = (p == 2) || so;
        e_ea = e_ind ? pw : {s0, s1};
        if (!e_ind) e_npc = b + 16'h2;
      end
      4: begin
        e_ill = (p > 1);
        e_ea = {8'h00, ix};
        e_npc = b;
      end
      5, 6: begin
        e_ind = (p > 1);
        e_ill = so && (m == 6);
        e_y = (p == 1 || p == 2);
        if (m == 5) e_ea = {8'h00, e_ind ? pb : s0} + ix;
        else e_ea = (e_ind ? pw : {s0, s1}) + ix;
        if (m == 6 && !e_ind) e_npc = b + 16'h2;
      end
      7, 8, 9: begin
        e_ill = (p == 1 || p == 2);
        chk_rel = (m != 8);
        chk_ea = (m != 7);
        off = (m == 9) ? s1 : (e_ind ? pb : s0);
        if (m == 9) e_npc = b + 16'h2;
        e_tgt = exp_tgt(e_npc, off);
      end
      default: e_ill = 1'b1;
    endcase
    wait_n = (rnd == 0) ? 2'h0 : 2'($urandom_range(0, 2));
    op_mode = adm_mode_t'((m == 10) ? 4'hf : 4'(m));
    short_only = so;
    pc_in = pc;
    start = 1'b1;
    @(posedge clk);
    @(negedge clk);
    pc_in = pc ^ 16'h0f0f; // Start while busy must be ignored
    @(negedge clk);
    start = 1'b0;
    check(16'(busy), 16'h1, "busy while decoding");
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    check(16'(done), 16'h1, "done");
    check(16'(illegal), 16'(e_ill), "illegal");
    if (!e_ill) begin
      check(16'(opcode), 16'(op), "opcode");
      if (chk_ea) check(ea, e_ea, "ea");
      if (chk_np) check(next_pc, e_npc, "next_pc");
      if (chk_rel) check(rel_target, e_tgt, "target");
      check(16'(is_rel), 16'(chk_rel), "is_rel");
      check(16'(is_ind), 16'(e_ind), "is_ind");
      check(16'(use_y), 16'(e_y), "use_y");
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    pc_in = 16'h0000;
    x_in = 8'h00;
    y_in = 8'h00;
    op_mode = M_INH;
    short_only = 1'b0;
    wait_n = 2'h0;
    n_errors = 0;
    checks_done = 0;
    seed_v = $urandom(44124);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(16'(busy), 16'h0, "busy after reset");
    check(16'(mem_rd), 16'h0, "mem_rd after reset");
    check(mem_addr, 16'h0000, "mem_addr after reset");
    check(16'(done), 16'h0, "done after reset");
    check(16'(opcode), 16'h0, "opcode after reset");
    // Round 0 is the all-ff corner, later rounds random with waits
    for (int r = 0; r < 4; r++) begin
      for (int m = 0; m < 11; m++)
        for (int p = 0; p < 4; p++)
          for (int s = 0; s < 2; s++)
            run_one(m, p, 1'(s), r);
      $display("Round %0d done", r);
    end
    give_verdict();
  end
endmodule // cpu_address_mode_decoder_test
`default_nettype wire
